// *** design/edpc_consts.svh ***
`ifndef EDPC_CONSTS_SVH
`define EDPC_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define EDC_CTRL_IDX 6'h1d
`define EDC_STAT_IDX 6'h1e
`define EDC_MASK_IDX 6'h1f

// Bit positions of the energy detect control register.
`define EDC_B_ENABLE 15
`define EDC_B_AUTO_UP 14
`define EDC_B_AUTO_DOWN 13
`define EDC_B_MANUAL 12
`define EDC_B_BURST_DIS 11
`define EDC_B_PSTATE 10
`define EDC_B_ERR_HIT 9
`define EDC_B_DATA_HIT 8
`define EDC_ERR_THR_LSB 4
`define EDC_DATA_THR_LSB 0
`define EDC_THR_W 4

// Reset values.
`define EDC_AUTO_UP_RST 1'h1
`define EDC_AUTO_DOWN_RST 1'h1
`define EDC_THR_RST 4'h1
`define EDC_IRQ_MASK_RST 3'h0

// Interrupt status bit positions.
`define EDC_IRQ_W 3
`define EDC_IRQ_DATA 0
`define EDC_IRQ_ERR 1
`define EDC_IRQ_PWR 2

// Pulse burst lengths.
`define EDC_BURST_LEN 3'h4
`define EDC_SINGLE_LEN 3'h1

// Timing: clock rate, quiet interval, sequence and pulse spacing.
`define EDC_CLK_MHZ 200
`define EDC_QUIET_MS 2000
`define EDC_SEQ_CYCLES 64
`define EDC_PULSE_GAP 16

// AXI responses.
`define EDC_RESP_OKAY 2'h0
`define EDC_RESP_SLVERR 2'h2

`endif

// *** design/edpc_pkg.sv ***
package edpc_pkg;

    // Power sequencer states, one-hot.
    typedef enum logic [3:0] {
        PS_DOWN = 4'h1,
        PS_RISE = 4'h2,
        PS_UP = 4'h4,
        PS_FALL = 4'h8
    } pwr_state_t;

    // Register select codes from address decode.
    typedef enum logic [1:0] {
        SEL_NONE = 2'h0,
        SEL_CTRL = 2'h1,
        SEL_STAT = 2'h2,
        SEL_MASK = 2'h3
    } reg_sel_t;

    // Complete state of the sequencer core.
    typedef struct packed {
        pwr_state_t st;
        logic energy_sense_enable;
        logic auto_power_up;
        logic auto_power_down;
        logic pulse_burst_disable;
        logic sense_power_state;
        logic error_threshold_hit;
        logic data_threshold_hit;
        logic [3:0] error_threshold;
        logic [3:0] data_threshold;
        logic [3:0] err_cnt;
        logic [3:0] data_cnt;
        logic err_met;
        logic data_met;
        logic manual_req;
        logic burst_go;
        logic drive_on;
        logic [31:0] quiet;
        logic [15:0] seq;
        logic [2:0] irq_st;
        logic [2:0] irq_msk;
        logic irq;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } core_t;

    // State of the pulse burst generator.
    typedef struct packed {
        logic [2:0] left;
        logic [7:0] gap;
        logic pulse;
    } burst_t;

endpackage

// *** design/edpc_sync2.sv ***
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for asynchronous level inputs.
module edpc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t q;
    sync_t d;

    // The first stage feeds only the second stage.
    always_comb begin
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    // No reset, so a strap level passes through while reset is held.
    always_ff @(posedge clk_sys) begin
        q <= d;
    end

    assign sync_out = q.s2;

endmodule

`default_nettype wire

// *** design/edpc_pulse_burst.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "edpc_consts.svh"

// Sends one or a burst of energy detect pulses on each start that arrives while idle.
module edpc_pulse_burst #(
    parameter int GAP = `EDC_PULSE_GAP
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic start,
    input wire logic single,
    output logic pulse,
    output logic busy
);

    edpc_pkg::burst_t q;
    edpc_pkg::burst_t d;

    // Each pulse is one cycle wide, then GAP idle cycles follow.
    always_comb begin
        d = q;
        d.pulse = 1'b0;
        if (srst) begin
            d = '0;
        end else if (start && q.left == 3'h0) begin
            d.left = single ? `EDC_SINGLE_LEN : `EDC_BURST_LEN;
            d.gap = 8'h0;
        end else if (q.left != 3'h0) begin
            if (q.gap == 8'h0) begin
                d.pulse = 1'b1;
                d.left = q.left - 3'h1;
                d.gap = 8'(GAP);
            end else begin
                d.gap = q.gap - 8'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        q <= d;
    end

    assign pulse = q.pulse;
    assign busy = (q.left != 3'h0);

endmodule

`default_nettype wire

// *** design/energy_detect_power_control.sv ***
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

`include "edpc_consts.svh"

module energy_detect_power_control #(
    parameter int unsigned QUIET_CYCLES =
        `EDC_QUIET_MS * 1000 * `EDC_CLK_MHZ,
    parameter int SEQ_CYCLES = `EDC_SEQ_CYCLES,
    parameter int PULSE_GAP = `EDC_PULSE_GAP
) (
    input wire logic clk_sys,
    input wire logic srst,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line side.
    input wire logic strap_energy_enable,
    input wire logic line_energy,
    input wire logic data_event,
    input wire logic error_event,
    output logic transmit_line_driver_on,
    output logic energy_pulse,
    output logic irq
);

    edpc_pkg::core_t q;
    edpc_pkg::core_t d;

    logic [1:0] pins_s;
    logic strap_s;
    logic energy_s;
    logic burst_busy;

    // Strap and line energy come from pins and are synchronised.
    edpc_sync2 #(
        .W(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .async_in({strap_energy_enable, line_energy}),
        .sync_out(pins_s)
    );

    assign strap_s = pins_s[1];
    assign energy_s = pins_s[0];

    // Pulse generator fired when the sequencer powers the line driver up from PS_DOWN.
    edpc_pulse_burst #(
        .GAP(PULSE_GAP)
    ) u_burst (
        .clk_sys(clk_sys),
        .srst(srst),
        .start(q.burst_go),
        .single(q.pulse_burst_disable),
        .pulse(energy_pulse),
        .busy(burst_busy)
    );

    // Maps a byte address onto one of the three registers.
    function automatic edpc_pkg::reg_sel_t reg_sel(input logic [7:0] a);
        if (a == {`EDC_CTRL_IDX, 2'h0}) begin
            reg_sel = edpc_pkg::SEL_CTRL;
        end else if (a == {`EDC_STAT_IDX, 2'h0}) begin
            reg_sel = edpc_pkg::SEL_STAT;
        end else if (a == {`EDC_MASK_IDX, 2'h0}) begin
            reg_sel = edpc_pkg::SEL_MASK;
        end else begin
            reg_sel = edpc_pkg::SEL_NONE;
        end
    endfunction

    // Packs the control register image for reads.
    function automatic logic [31:0] ctrl_image(input edpc_pkg::core_t s);
        logic [31:0] v;
        v = 32'h0;
        v[`EDC_B_ENABLE] = s.energy_sense_enable;
        v[`EDC_B_AUTO_UP] = s.auto_power_up;
        v[`EDC_B_AUTO_DOWN] = s.auto_power_down;
        v[`EDC_B_BURST_DIS] = s.pulse_burst_disable;
        v[`EDC_B_PSTATE] = s.sense_power_state;
        v[`EDC_B_ERR_HIT] = s.error_threshold_hit;
        v[`EDC_B_DATA_HIT] = s.data_threshold_hit;
        v[`EDC_ERR_THR_LSB +: `EDC_THR_W] = s.error_threshold;
        v[`EDC_DATA_THR_LSB +: `EDC_THR_W] = s.data_threshold;
        ctrl_image = v;
    endfunction

    edpc_pkg::reg_sel_t wsel;
    edpc_pkg::reg_sel_t rsel;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_write;
    logic data_met_now;
    logic err_met_now;

    // Bus handshakes: one write and one read under way at a time.
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign do_write = q.aw_got && q.w_got && !q.bvalid;
    assign wsel = reg_sel(q.awaddr);
    assign rsel = reg_sel(s_axi_araddr);
    assign data_met_now = (q.data_cnt >= q.data_threshold);
    assign err_met_now = (q.err_cnt >= q.error_threshold);

    // Next-state logic for bus slave, registers, counters and sequencer.
    always_comb begin
        d = q;
        d.manual_req = 1'b0;
        d.burst_go = 1'b0;

        // Write address and data are taken independently.
        if (aw_hs) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end

        if (w_hs) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end

        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        // Register write once both halves are held.
        if (do_write) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `EDC_RESP_OKAY;
            if (wsel == edpc_pkg::SEL_CTRL) begin
                if (q.wstrb[0]) begin
                    d.error_threshold =
                        q.wdata[`EDC_ERR_THR_LSB +: `EDC_THR_W];
                    d.data_threshold =
                        q.wdata[`EDC_DATA_THR_LSB +: `EDC_THR_W];
                end
                if (q.wstrb[1]) begin
                    d.energy_sense_enable = q.wdata[`EDC_B_ENABLE];
                    d.auto_power_up = q.wdata[`EDC_B_AUTO_UP];
                    d.auto_power_down = q.wdata[`EDC_B_AUTO_DOWN];
                    d.pulse_burst_disable = q.wdata[`EDC_B_BURST_DIS];
                    d.manual_req = q.wdata[`EDC_B_MANUAL];
                end
            end else if (wsel == edpc_pkg::SEL_STAT) begin
                if (q.wstrb[0]) begin
                    d.irq_st = q.irq_st & ~q.wdata[2:0];
                end
            end else if (wsel == edpc_pkg::SEL_MASK) begin
                if (q.wstrb[0]) begin
                    d.irq_msk = q.wdata[2:0];
                end
            end else begin
                d.bresp = `EDC_RESP_SLVERR;
            end
        end

        // Register read; reading control clears both threshold flags.
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        if (ar_hs) begin
            d.rvalid = 1'b1;
            d.rresp = `EDC_RESP_OKAY;
            if (rsel == edpc_pkg::SEL_CTRL) begin
                d.rdata = ctrl_image(q);
                d.error_threshold_hit = 1'b0;
                d.data_threshold_hit = 1'b0;
            end else if (rsel == edpc_pkg::SEL_STAT) begin
                d.rdata = {29'h0, q.irq_st};
            end else if (rsel == edpc_pkg::SEL_MASK) begin
                d.rdata = {29'h0, q.irq_msk};
            end else begin
                d.rdata = 32'h0;
                d.rresp = `EDC_RESP_SLVERR;
            end
        end

        // Saturating event counters.
        if (data_event && q.data_cnt != 4'hf) begin
            d.data_cnt = q.data_cnt + 4'h1;
        end

        if (error_event && q.err_cnt != 4'hf) begin
            d.err_cnt = q.err_cnt + 4'h1;
        end

        // Quiet timer drops stale counts after a long data-free spell.
        if (data_event) begin
            d.quiet = 32'h0;
        end else if (q.quiet >= QUIET_CYCLES - 1) begin
            d.quiet = 32'h0;
            d.data_cnt = 4'h0;
            d.err_cnt = 4'h0;
        end else begin
            d.quiet = q.quiet + 32'h1;
        end

        // Flags are set on crossing the threshold; a set beats a read.
        d.data_met = data_met_now;
        d.err_met = err_met_now;
        if (data_met_now && !q.data_met) begin
            d.data_threshold_hit = 1'b1;
            d.irq_st[`EDC_IRQ_DATA] = 1'b1;
        end

        if (err_met_now && !q.err_met) begin
            d.error_threshold_hit = 1'b1;
            d.irq_st[`EDC_IRQ_ERR] = 1'b1;
        end

        // Power sequencer; error counts never steer it.
        if (!q.energy_sense_enable) begin
            d.st = edpc_pkg::PS_UP;
            d.drive_on = 1'b1;
            d.sense_power_state = 1'b1;
            d.seq = 16'h0;
        end else begin
            case (q.st)
                edpc_pkg::PS_DOWN: begin
                    if (q.manual_req ||
                        (q.auto_power_up && data_met_now)) begin
                        d.st = edpc_pkg::PS_RISE;
                        d.seq = 16'h0;
                        d.drive_on = 1'b1;
                        d.burst_go = 1'b1;
                    end
                end

                // The driver counts as up only once the burst has ended.
                edpc_pkg::PS_RISE: begin
                    if (q.seq >= 16'(SEQ_CYCLES - 1) && !burst_busy) begin
                        d.st = edpc_pkg::PS_UP;
                        d.sense_power_state = 1'b1;
                        d.data_cnt = 4'h0;
                        d.err_cnt = 4'h0;
                        d.irq_st[`EDC_IRQ_PWR] = 1'b1;
                    end else begin
                        d.seq = q.seq + 16'h1;
                    end
                end

                edpc_pkg::PS_UP: begin
                    if (q.manual_req ||
                        (q.auto_power_down && !energy_s)) begin
                        d.st = edpc_pkg::PS_FALL;
                        d.seq = 16'h0;
                    end
                end

                edpc_pkg::PS_FALL: begin
                    if (q.seq >= 16'(SEQ_CYCLES - 1)) begin
                        d.st = edpc_pkg::PS_DOWN;
                        d.drive_on = 1'b0;
                        d.sense_power_state = 1'b0;
                        d.data_cnt = 4'h0;
                        d.err_cnt = 4'h0;
                        d.irq_st[`EDC_IRQ_PWR] = 1'b1;
                    end else begin
                        d.seq = q.seq + 16'h1;
                    end
                end

                default: begin
                    d.st = edpc_pkg::PS_UP;
                end
            endcase
        end

        // Registered level interrupt from unmasked sticky status.
        d.irq = |(d.irq_st & d.irq_msk);

        // Synchronous reset; enable takes the synchronised strap.
        if (srst) begin
            d = '0;
            d.st = edpc_pkg::PS_UP;
            d.drive_on = 1'b1;
            d.sense_power_state = 1'b1;
            d.energy_sense_enable = strap_s;
            d.auto_power_up = `EDC_AUTO_UP_RST;
            d.auto_power_down = `EDC_AUTO_DOWN_RST;
            d.error_threshold = `EDC_THR_RST;
            d.data_threshold = `EDC_THR_RST;
            d.irq_msk = `EDC_IRQ_MASK_RST;
        end
    end

    // Single state register.
    always_ff @(posedge clk_sys) begin
        q <= d;
    end

    // Ready terms are combinational; all data outputs are registered.
    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign transmit_line_driver_on = q.drive_on;
    assign irq = q.irq;

endmodule

`default_nettype wire

// *** verif/link_partner_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Far end of the cable: line energy plus counted data or error events.
module link_partner_model (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic talk,
    input wire logic go,
    input wire logic err_kind,
    input wire logic [3:0] count,
    input wire logic [3:0] gap,
    output logic line_energy,
    output logic data_event,
    output logic error_event,
    output logic busy
);
    logic [3:0] left_q;
    logic [3:0] wait_q;

    // Energy is on the wire only while the partner transmits, fixed pairs.
    assign line_energy = talk;
    assign busy = (left_q != 4'h0);

    // One-cycle events spaced by a gap, so answers come fast or slow.
    always_ff @(posedge clk_sys) begin
        data_event <= 1'b0;
        error_event <= 1'b0;
        if (srst) begin
            left_q <= 4'h0;
            wait_q <= 4'h0;
        end else if (go) begin
            left_q <= count;
            wait_q <= 4'h0;
        end else if (busy && wait_q == 4'h0) begin
            data_event <= talk && !err_kind;
            error_event <= talk && err_kind;
            left_q <= left_q - 4'h1;
            wait_q <= gap;
        end else if (busy) begin
            wait_q <= wait_q - 4'h1;
        end
    end
endmodule

`default_nettype wire

// *** verif/edpc_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none

// Watches bus answers and the energy pulse burst at the ports.
module edpc_monitor (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic transmit_line_driver_on,
    input wire logic energy_pulse
);
    logic [3:0] pulses_q;
    logic drv_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // Counts pulses since the driver last came on.
    always_ff @(posedge clk_sys) begin
        drv_q <= transmit_line_driver_on;
        if (srst || (transmit_line_driver_on && !drv_q)) begin
            pulses_q <= 4'h0;
        end else if (energy_pulse) begin
            pulses_q <= pulses_q + 4'h1;
        end
    end

    property p_pulse_gap;
        energy_pulse |=> !energy_pulse [*8];
    endproperty
    a_pulse_gap: assert property (p_pulse_gap)
        else $error("energy pulses too close together");

    property p_pulse_drv;
        energy_pulse |-> transmit_line_driver_on;
    endproperty
    a_pulse_drv: assert property (p_pulse_drv)
        else $error("energy pulse while driver is off");

    property p_first_pulse;
        $rose(transmit_line_driver_on) |-> ##[1:3] energy_pulse;
    endproperty
    a_first_pulse: assert property (p_first_pulse)
        else $error("no pulse after driver power-up");

    property p_burst_max;
        pulses_q <= 4'h4;
    endproperty
    a_burst_max: assert property (p_burst_max)
        else $error("more than four pulses in one burst");

    property p_write_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write response late");

    property p_read_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_resp: assert property (p_read_resp)
        else $error("read data late");

    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block)
        else $error("read address taken while data pending");

    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
            |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");

    property p_upper_zero;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read data not zero");
endmodule

bind energy_detect_power_control edpc_monitor mon (
    .clk_sys(clk_sys), .srst(srst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .transmit_line_driver_on(transmit_line_driver_on),
    .energy_pulse(energy_pulse)
);

`default_nettype wire

// *** verif/energy_detect_power_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module energy_detect_power_control_tb;
    localparam int SEQ = 64;
    localparam logic [7:0] CTRL = 8'h74;
    localparam logic [7:0] STAT = 8'h78;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] aw_addr = 8'h00;
    logic [7:0] ar_addr = 8'h00;
    logic [31:0] w_data = 32'h0;
    logic aw_valid = 1'b0;
    logic w_valid = 1'b0;
    logic b_ready = 1'b0;
    logic ar_valid = 1'b0;
    logic r_ready = 1'b0;
    logic talk = 1'b1;
    logic strap = 1'b1;
    logic ev_go = 1'b0;
    logic ev_err = 1'b0;
    logic [3:0] ev_n = 4'h0;
    logic [3:0] ev_gap = 4'h0;
    wire logic aw_rdy, w_rdy, b_valid, ar_rdy, r_valid, energy, data_ev;
    wire logic err_ev, drv_on, pulse, irq, ev_busy;
    wire logic [1:0] b_resp, r_resp;
    wire logic [31:0] r_data;
    int fail_count = 0;
    int checked = 0;
    int pulse_n = 0;
    int cycles = 0;
    int n;
    int p0;
    logic [31:0] seed = 32'ha90f;
    logic [31:0] rd;
    logic [1:0] resp;
    logic [3:0] d;

    energy_detect_power_control #(.QUIET_CYCLES(200)) uut (
        .clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(aw_addr),
        .s_axi_awvalid(aw_valid), .s_axi_awready(aw_rdy),
        .s_axi_wdata(w_data), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_valid),
        .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
        .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
        .s_axi_arvalid(ar_valid), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
        .s_axi_rready(r_ready), .strap_energy_enable(strap),
        .line_energy(energy), .data_event(data_ev), .error_event(err_ev),
        .transmit_line_driver_on(drv_on), .energy_pulse(pulse), .irq(irq)
    );

    link_partner_model partner (
        .clk_sys(clk_sys), .srst(srst), .talk(talk), .go(ev_go),
        .err_kind(ev_err), .count(ev_n), .gap(ev_gap), .line_energy(energy),
        .data_event(data_ev), .error_event(err_ev), .busy(ev_busy)
    );

    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Counts pulses and cycles; a hung run is cut short.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (pulse === 1'b1) begin
            pulse_n <= pulse_n + 1;
        end
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            print_verdict();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Readback of a written control word: manual clear, flags clear.
    function automatic logic [31:0] exp_ctrl(input logic [15:0] w,
                                             input logic ps);
        return {16'h0, w[15:13], 1'b0, w[11], ps, 2'b00, w[7:0]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        aw_addr <= a;
        w_data <= v;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (aw_rdy === 1'b1) aw_valid <= 1'b0;
            if (w_rdy === 1'b1) w_valid <= 1'b0;
        end while (b_valid !== 1'b1);
        resp = b_resp;
        b_ready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge clk_sys);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (ar_rdy === 1'b1) ar_valid <= 1'b0;
        end while (r_valid !== 1'b1);
        rd = r_data;
        resp = r_resp;
        r_ready <= 1'b0;
    endtask

    task automatic wait_drv(input logic v, input int lim);
        n = 0;
        while (drv_on !== v && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        check({31'h0, drv_on}, {31'h0, v});
    endtask

    task automatic send(input logic k, input logic [3:0] cnt);
        @(posedge clk_sys);
        seed = lfsr(seed);
        ev_err <= k;
        ev_n <= cnt;
        ev_gap <= seed[3:0];
        ev_go <= 1'b1;
        @(posedge clk_sys);
        ev_go <= 1'b0;
        @(posedge clk_sys);
        while (ev_busy === 1'b1) @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence of scenarios.
    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        rdr(CTRL);
        check(rd, exp_ctrl(16'he011, 1'b1));
        rdr(8'h00);
        check({rd[29:0], resp}, 32'h2);
        wr(8'h40, 32'h1234);
        check({30'h0, resp}, 32'h2);
        wr(8'h7c, 32'h7);
        rdr(8'h7c);
        check(rd, 32'h7);
        $display("test reset_and_map done");
        talk <= 1'b0;
        wait_drv(1'b0, SEQ + 20);
        check({31'h0, n >= SEQ}, 32'h1);
        rdr(CTRL);
        check(rd & 32'h400, 32'h0);
        check({31'h0, irq}, 32'h1);
        rdr(STAT);
        check(rd & 32'h4, 32'h4);
        wr(STAT, 32'h7);
        rdr(STAT);
        check({rd[30:0], irq}, 32'h0);
        $display("test auto_down done");
        seed = lfsr(seed);
        d = 4'h2 + {2'h0, seed[1:0]};
        wr(CTRL, 32'he0f0 | d);
        rdr(CTRL);
        check(rd, exp_ctrl(16'he0f0 | d, 1'b0));
        talk <= 1'b1;
        send(1'b0, d - 4'h1);
        repeat (30) @(posedge clk_sys);
        check({31'h0, drv_on}, 32'h0);
        p0 = pulse_n;
        send(1'b0, 4'h1);
        wait_drv(1'b1, 20);
        repeat (SEQ + 80) @(posedge clk_sys);
        check(pulse_n - p0, 32'h4);
        rdr(CTRL);
        check(rd & 32'h500, 32'h500);
        rdr(CTRL);
        check(rd & 32'h100, 32'h0);
        $display("test auto_up done");
        wr(CTRL, 32'he020 | d);
        send(1'b1, 4'h2);
        repeat (10) @(posedge clk_sys);
        rdr(CTRL);
        check(rd & 32'h700, 32'h600);
        check({31'h0, drv_on}, 32'h1);
        rdr(CTRL);
        check(rd & 32'h200, 32'h0);
        $display("test error_events done");
        wr(STAT, 32'h7);
        wr(CTRL, 32'h9820 | d);
        wait_drv(1'b0, SEQ + 10);
        rdr(CTRL);
        check(rd, exp_ctrl(16'h8820 | d, 1'b0));
        p0 = pulse_n;
        wr(CTRL, 32'h9820 | d);
        wait_drv(1'b1, 10);
        repeat (SEQ + 20) @(posedge clk_sys);
        check(pulse_n - p0, 32'h1);
        rdr(CTRL);
        check(rd, exp_ctrl(16'h8820 | d, 1'b1));
        $display("test manual done");
        wr(CTRL, 32'h9013);
        wait_drv(1'b0, SEQ + 10);
        wr(CTRL, 32'hc013);
        send(1'b0, 4'h2);
        repeat (400) @(posedge clk_sys);
        send(1'b0, 4'h2);
        repeat (30) @(posedge clk_sys);
        check({31'h0, drv_on}, 32'h0);
        send(1'b0, 4'h1);
        wait_drv(1'b1, 20);
        $display("test quiet_reset done");
        repeat (SEQ + 20) @(posedge clk_sys);
        wr(CTRL, 32'h6013);
        talk <= 1'b0;
        repeat (SEQ + 40) @(posedge clk_sys);
        check({31'h0, drv_on}, 32'h1);
        $display("test disable done");
        strap <= 1'b0;
        srst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        rdr(CTRL);
        check(rd, exp_ctrl(16'h6011, 1'b1));
        $display("test strap done");
        print_verdict();
    end
endmodule

`default_nettype wire
